// ### src/bst_pkg.sv
// Constants and types shared by the boundary-scan test port.
// Assumes a single test clock domain for the port and a core clock domain for configuration data.
`default_nettype none

package bst_pkg;

  // ----------------------------------------------------------------
  // Register lengths
  // ----------------------------------------------------------------
  localparam int IR_LEN       = 10;
  localparam int ID_LEN       = 32;
  localparam int USER_LEN     = 7;
  localparam int BSR_LEN_SMALL = 438;
  localparam int BSR_LEN_MID1 = 690;
  localparam int BSR_LEN_MID2 = 798;
  localparam int BSR_LEN_BIG  = 1050;
  localparam int BSR_LEN      = BSR_LEN_SMALL;
  localparam int CFG_W        = 8;
  localparam int FIFO_DEPTH   = 8;

  // ----------------------------------------------------------------
  // Instruction encodings
  // ----------------------------------------------------------------
  localparam logic [IR_LEN-1:0] OP_EXTEST    = 10'h000;
  localparam logic [IR_LEN-1:0] OP_CFG_START = 10'h002;
  localparam logic [IR_LEN-1:0] OP_CFG_DATA  = 10'h003;
  localparam logic [IR_LEN-1:0] OP_CFG_DONE  = 10'h004;
  localparam logic [IR_LEN-1:0] OP_SAMPLE    = 10'h005;
  localparam logic [IR_LEN-1:0] OP_IDCODE    = 10'h006;
  localparam logic [IR_LEN-1:0] OP_USERCODE  = 10'h007;
  localparam logic [IR_LEN-1:0] OP_BYPASS    = 10'h3FF;
  localparam logic [IR_LEN-1:0] IR_CAPTURE   = 10'h001;
  localparam logic [IR_LEN-1:0] IR_RESET     = OP_IDCODE;

  // ----------------------------------------------------------------
  // Identification and signature words (values arbitrary)
  // ----------------------------------------------------------------
  localparam logic [3:0]  ID_VERSION = 4'hA;
  localparam logic [15:0] ID_PART    = 16'h5A3C;
  localparam logic [10:0] ID_MAKER   = 11'h2B5;
  localparam logic [ID_LEN-1:0] IDCODE_WORD = {ID_VERSION, ID_PART, ID_MAKER, 1'h1};
  localparam logic [ID_LEN-USER_LEN-1:0] USER_FIXED = 25'h0F0F0F0;

  // ----------------------------------------------------------------
  // Controller states and data-register selection
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR, ST_UPD_DR,
    ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
  } bst_tap_t;

  typedef enum logic [2:0] {SEL_BYP, SEL_BSR, SEL_ID, SEL_USER, SEL_CFG} bst_sel_t;

endpackage : bst_pkg

`default_nettype wire

// ### src/bst_fifo.sv
// Single-clock FIFO with valid/ready on both sides.
// Assumes both sides run on the same clock; DEPTH is a power of two.
`default_nettype none

module bst_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             srst_in,
  // Fill side
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  // Drain side
  output logic                  out_valid_out,
  output logic [WIDTH-1:0]      out_data_out,
  input  wire logic             out_ready_in
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wr;
    logic [AW:0]                 rd;
  } bst_fifo_t;

  bst_fifo_t f;
  bst_fifo_t next_f;
  logic      full;
  logic      empty;

  assign full          = (f.wr[AW] != f.rd[AW]) && (f.wr[AW-1:0] == f.rd[AW-1:0]);
  assign empty         = (f.wr == f.rd);
  assign in_ready_out  = !full;
  assign out_valid_out = !empty;
  assign out_data_out  = f.mem[f.rd[AW-1:0]];

  always_comb begin
    next_f = f;
    if (in_valid_in && !full) begin
      next_f.mem[f.wr[AW-1:0]] = in_data_in;
      next_f.wr = f.wr + 1'h1;
    end
    if (out_ready_in && !empty) begin
      next_f.rd = f.rd + 1'h1;
    end
    if (srst_in) begin
      next_f.wr = '0;
      next_f.rd = '0;
    end
  end

  always_ff @(posedge clk_in) begin
    f <= next_f;
  end

  chk_fifo_no_overflow: assert property (@(posedge clk_in) disable iff (srst_in)
    full |=> (f.wr == $past(f.wr)))
    else $error("FIFO write pointer moved while full");

endmodule : bst_fifo

`default_nettype wire

// ### src/bst_test_port.sv
// Boundary-scan test access port with configuration download path.
// Assumes TCK_IN comes from an external controller, may stop between scans, and is unrelated to CORE_CLK_IN.
`default_nettype none

module bst_test_port (
  // Core clock and reset
  input  wire logic                        CORE_CLK_IN,
  input  wire logic                        SRST_IN,
  // Test access port
  input  wire logic                        TCK_IN,
  input  wire logic                        TMS_IN,
  input  wire logic                        TDI_IN,
  output logic                             TDO_OUT,
  output logic                             TDO_OE_OUT,
  // Boundary cells
  input  wire logic [bst_pkg::BSR_LEN-1:0] PIN_LEVEL_IN,
  output logic      [bst_pkg::BSR_LEN-1:0] PIN_TEST_OUT,
  output logic                             PIN_TEST_EN_OUT,
  // User signature bits
  input  wire logic [bst_pkg::USER_LEN-1:0] USER_CODE_IN,
  // Configuration stream to the core
  output logic      [bst_pkg::CFG_W-1:0]   CFG_DATA_OUT,
  output logic                             CFG_VALID_OUT,
  input  wire logic                        CFG_READY_IN,
  output logic                             CONFIGURING_OUT
);

  // ----------------------------------------------------------------
  // State of both domains
  // ----------------------------------------------------------------
  typedef struct packed {
    bst_pkg::bst_tap_t                 state;
    logic                              rst_s1;
    logic                              rst_s2;
    logic [bst_pkg::IR_LEN-1:0]        ir_shift;
    logic [bst_pkg::IR_LEN-1:0]        ir;
    logic                              byp;
    logic [bst_pkg::ID_LEN-1:0]        id_shift;
    logic [bst_pkg::BSR_LEN-1:0]       bsr_shift;
    logic [bst_pkg::BSR_LEN-1:0]       bsr_upd;
    logic [bst_pkg::BSR_LEN-1:0]       pin_s1;
    logic [bst_pkg::BSR_LEN-1:0]       pin_s2;
    logic [bst_pkg::USER_LEN-1:0]      uc_s1;
    logic [bst_pkg::USER_LEN-1:0]      uc_s2;
    logic                              cfg_active;
    logic                              ext_mode;
    logic [bst_pkg::CFG_W-1:0]         xfer_data;
    logic                              req;
    logic                              ack_s1;
    logic                              ack_s2;
    logic                              overrun;
  } bst_link_t;

  typedef struct packed {
    logic                      req_s1;
    logic                      req_s2;
    logic                      ack;
    logic                      conf_s1;
    logic                      conf_s2;
    logic                      configuring;
    logic                      out_valid;
    logic [bst_pkg::CFG_W-1:0] out_data;
  } bst_core_t;

  bst_link_t t;
  bst_link_t next_t;
  bst_core_t c;
  bst_core_t next_c;
  logic      tdo;
  logic      tdo_oe;
  logic      serial;
  logic      link_busy;
  logic      fifo_in_valid;
  logic      fifo_in_ready;
  logic      fifo_out_valid;
  logic      fifo_out_ready;
  logic [bst_pkg::CFG_W-1:0] fifo_out_data;

  // ----------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------
  function automatic bst_pkg::bst_sel_t dr_sel(input logic [bst_pkg::IR_LEN-1:0] op, input logic cfg);
    bst_pkg::bst_sel_t s;
    s = bst_pkg::SEL_BYP;
    if (op == bst_pkg::OP_EXTEST || op == bst_pkg::OP_SAMPLE) begin
      // Pin tests would fight the loading fabric, so they fall back to bypass here
      s = cfg ? bst_pkg::SEL_BYP : bst_pkg::SEL_BSR;
    end else if (op == bst_pkg::OP_IDCODE) begin
      s = bst_pkg::SEL_ID;
    end else if (op == bst_pkg::OP_USERCODE) begin
      s = bst_pkg::SEL_USER;
    end else if (op == bst_pkg::OP_CFG_DATA) begin
      s = bst_pkg::SEL_CFG;
    end
    return s;
  endfunction : dr_sel

  assign link_busy = (t.req != t.ack_s2);

  // ----------------------------------------------------------------
  // Test clock domain
  // ----------------------------------------------------------------
  always_comb begin
    next_t = t;
    next_t.rst_s1 = SRST_IN;
    next_t.rst_s2 = t.rst_s1;
    next_t.pin_s1 = PIN_LEVEL_IN;
    next_t.pin_s2 = t.pin_s1;
    next_t.uc_s1  = USER_CODE_IN;
    next_t.uc_s2  = t.uc_s1;
    next_t.ack_s1 = c.ack;
    next_t.ack_s2 = t.ack_s1;

    unique case (t.state)
      bst_pkg::ST_TLR:    next_t.state = TMS_IN ? bst_pkg::ST_TLR    : bst_pkg::ST_RTI;
      bst_pkg::ST_RTI:    next_t.state = TMS_IN ? bst_pkg::ST_SEL_DR : bst_pkg::ST_RTI;
      bst_pkg::ST_SEL_DR: next_t.state = TMS_IN ? bst_pkg::ST_SEL_IR : bst_pkg::ST_CAP_DR;
      bst_pkg::ST_CAP_DR: next_t.state = TMS_IN ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
      bst_pkg::ST_SH_DR:  next_t.state = TMS_IN ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
      bst_pkg::ST_EX1_DR: next_t.state = TMS_IN ? bst_pkg::ST_UPD_DR : bst_pkg::ST_PAU_DR;
      bst_pkg::ST_PAU_DR: next_t.state = TMS_IN ? bst_pkg::ST_EX2_DR : bst_pkg::ST_PAU_DR;
      bst_pkg::ST_EX2_DR: next_t.state = TMS_IN ? bst_pkg::ST_UPD_DR : bst_pkg::ST_SH_DR;
      bst_pkg::ST_UPD_DR: next_t.state = TMS_IN ? bst_pkg::ST_SEL_DR : bst_pkg::ST_RTI;
      bst_pkg::ST_SEL_IR: next_t.state = TMS_IN ? bst_pkg::ST_TLR    : bst_pkg::ST_CAP_IR;
      bst_pkg::ST_CAP_IR: next_t.state = TMS_IN ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
      bst_pkg::ST_SH_IR:  next_t.state = TMS_IN ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
      bst_pkg::ST_EX1_IR: next_t.state = TMS_IN ? bst_pkg::ST_UPD_IR : bst_pkg::ST_PAU_IR;
      bst_pkg::ST_PAU_IR: next_t.state = TMS_IN ? bst_pkg::ST_EX2_IR : bst_pkg::ST_PAU_IR;
      bst_pkg::ST_EX2_IR: next_t.state = TMS_IN ? bst_pkg::ST_UPD_IR : bst_pkg::ST_SH_IR;
      bst_pkg::ST_UPD_IR: next_t.state = TMS_IN ? bst_pkg::ST_SEL_DR : bst_pkg::ST_RTI;
    endcase

    unique case (t.state)
      bst_pkg::ST_TLR: begin
        next_t.ir = bst_pkg::IR_RESET;
      end
      bst_pkg::ST_CAP_IR: begin
        next_t.ir_shift = bst_pkg::IR_CAPTURE;
      end
      bst_pkg::ST_SH_IR: begin
        next_t.ir_shift = {TDI_IN, t.ir_shift[bst_pkg::IR_LEN-1:1]};
      end
      bst_pkg::ST_UPD_IR: begin
        next_t.ir = t.ir_shift;
        if (t.ir_shift == bst_pkg::OP_CFG_START) begin
          next_t.cfg_active = 1'h1;
          next_t.overrun    = 1'h0;
        end else if (t.ir_shift == bst_pkg::OP_CFG_DONE) begin
          next_t.cfg_active = 1'h0;
        end
      end
      bst_pkg::ST_CAP_DR: begin
        unique case (dr_sel(t.ir, t.cfg_active))
          bst_pkg::SEL_BSR:  next_t.bsr_shift = t.pin_s2;
          bst_pkg::SEL_ID:   next_t.id_shift  = bst_pkg::IDCODE_WORD;
          bst_pkg::SEL_USER: next_t.id_shift  = {bst_pkg::USER_FIXED, t.uc_s2};
          bst_pkg::SEL_CFG:  next_t.id_shift  = {30'h0, t.overrun, !link_busy};
          default:           next_t.byp       = 1'h0;
        endcase
      end
      bst_pkg::ST_SH_DR: begin
        unique case (dr_sel(t.ir, t.cfg_active))
          bst_pkg::SEL_BSR:  next_t.bsr_shift = {TDI_IN, t.bsr_shift[bst_pkg::BSR_LEN-1:1]};
          bst_pkg::SEL_ID,
          bst_pkg::SEL_USER: next_t.id_shift  = {TDI_IN, t.id_shift[bst_pkg::ID_LEN-1:1]};
          bst_pkg::SEL_CFG:  next_t.id_shift[bst_pkg::CFG_W-1:0] = {TDI_IN, t.id_shift[bst_pkg::CFG_W-1:1]};
          default:           next_t.byp       = TDI_IN;
        endcase
      end
      bst_pkg::ST_UPD_DR: begin
        if (dr_sel(t.ir, t.cfg_active) == bst_pkg::SEL_BSR) begin
          next_t.bsr_upd = t.bsr_shift;
        end else if (dr_sel(t.ir, t.cfg_active) == bst_pkg::SEL_CFG) begin
          // A word completed while the previous one is still in flight is dropped and flagged
          if (link_busy) begin
            next_t.overrun = 1'h1;
          end else begin
            next_t.xfer_data = t.id_shift[bst_pkg::CFG_W-1:0];
            next_t.req       = !t.req;
          end
        end
      end
      default: begin
      end
    endcase

    if (t.rst_s2) begin
      next_t.state      = bst_pkg::ST_TLR;
      next_t.ir         = bst_pkg::IR_RESET;
      next_t.ir_shift   = '0;
      next_t.byp        = 1'h0;
      next_t.id_shift   = '0;
      next_t.bsr_shift  = '0;
      next_t.bsr_upd    = '0;
      next_t.cfg_active = 1'h0;
      next_t.xfer_data  = '0;
      next_t.req        = 1'h0;
      next_t.overrun    = 1'h0;
    end
    next_t.ext_mode = (next_t.ir == bst_pkg::OP_EXTEST) && !next_t.cfg_active;
  end

  always_ff @(posedge TCK_IN) begin
    t <= next_t;
  end

  // ----------------------------------------------------------------
  // Falling-edge output stage
  // ----------------------------------------------------------------
  always_comb begin
    unique case (dr_sel(t.ir, t.cfg_active))
      bst_pkg::SEL_BSR: serial = t.bsr_shift[0];
      bst_pkg::SEL_ID,
      bst_pkg::SEL_USER,
      bst_pkg::SEL_CFG: serial = t.id_shift[0];
      default:          serial = t.byp;
    endcase
    if (t.state == bst_pkg::ST_SH_IR) begin
      serial = t.ir_shift[0];
    end
  end

  always_ff @(negedge TCK_IN) begin
    if (t.rst_s2) begin
      tdo    <= 1'h0;
      tdo_oe <= 1'h0;
    end else begin
      tdo    <= serial;
      tdo_oe <= (t.state == bst_pkg::ST_SH_DR) || (t.state == bst_pkg::ST_SH_IR);
    end
  end

  assign TDO_OUT         = tdo;
  assign TDO_OE_OUT      = tdo_oe;
  assign PIN_TEST_OUT    = t.bsr_upd;
  assign PIN_TEST_EN_OUT = t.ext_mode;

  // ----------------------------------------------------------------
  // Core clock domain
  // ----------------------------------------------------------------
  // The word register is held still by the handshake, so reading it here is safe
  assign fifo_in_valid  = (c.req_s2 != c.ack);
  assign fifo_out_ready = !c.out_valid || CFG_READY_IN;

  always_comb begin
    next_c = c;
    next_c.req_s1      = t.req;
    next_c.req_s2      = c.req_s1;
    next_c.conf_s1     = t.cfg_active;
    next_c.conf_s2     = c.conf_s1;
    next_c.configuring = c.conf_s2;
    // Acknowledge only once the FIFO takes the word, which holds off the link side
    if (fifo_in_valid && fifo_in_ready) begin
      next_c.ack = c.req_s2;
    end
    if (fifo_out_ready) begin
      next_c.out_valid = fifo_out_valid;
      if (fifo_out_valid) begin
        next_c.out_data = fifo_out_data;
      end
    end
    if (SRST_IN) begin
      next_c = '0;
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    c <= next_c;
  end

  bst_fifo #(
    .WIDTH (bst_pkg::CFG_W),
    .DEPTH (bst_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (CORE_CLK_IN),
    .srst_in       (SRST_IN),
    .in_valid_in   (fifo_in_valid),
    .in_data_in    (t.xfer_data),
    .in_ready_out  (fifo_in_ready),
    .out_valid_out (fifo_out_valid),
    .out_data_out  (fifo_out_data),
    .out_ready_in  (fifo_out_ready)
  );

  assign CFG_DATA_OUT    = c.out_data;
  assign CFG_VALID_OUT   = c.out_valid;
  assign CONFIGURING_OUT = c.configuring;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_tms_reset_walk: assert property (@(posedge TCK_IN) disable iff (t.rst_s2)
    TMS_IN [*5] |=> (t.state == bst_pkg::ST_TLR))
    else $error("Five TMS highs did not reach test-logic-reset");

  chk_tdo_float: assert property (@(posedge TCK_IN) disable iff (t.rst_s2)
    ##1 (TDO_OE_OUT == (t.state == bst_pkg::ST_SH_DR || t.state == bst_pkg::ST_SH_IR)))
    else $error("TDO enable does not follow shift states");

  chk_ir_load: assert property (@(posedge TCK_IN) disable iff (t.rst_s2)
    (t.state == bst_pkg::ST_CAP_IR) ##1 (t.state == bst_pkg::ST_SH_IR) [*8] ##1 (t.state == bst_pkg::ST_SH_IR) [*2]
    ##1 (t.state == bst_pkg::ST_EX1_IR) ##1 (t.state == bst_pkg::ST_UPD_IR)
    |=> (t.ir[9] == $past(TDI_IN, 3)) && (t.ir[0] == $past(TDI_IN, 12)))
    else $error("Instruction register is not ten bits long");

  chk_id_lsb_one: assert property (@(posedge TCK_IN) disable iff (t.rst_s2)
    (t.state == bst_pkg::ST_CAP_DR && dr_sel(t.ir, t.cfg_active) == bst_pkg::SEL_ID)
    |=> t.id_shift[0] && (t.state != bst_pkg::ST_SH_DR || TDO_OUT))
    else $error("Identification word does not start with a one");

  chk_id_fields: assert property (@(posedge TCK_IN) disable iff (t.rst_s2)
    (t.state == bst_pkg::ST_CAP_DR && dr_sel(t.ir, t.cfg_active) == bst_pkg::SEL_ID)
    |=> (t.id_shift[31:28] == bst_pkg::ID_VERSION) && (t.id_shift[11:1] == bst_pkg::ID_MAKER))
    else $error("Identification word fields misplaced");

  chk_user_sig: assert property (@(posedge TCK_IN) disable iff (t.rst_s2)
    (t.state == bst_pkg::ST_CAP_DR && dr_sel(t.ir, t.cfg_active) == bst_pkg::SEL_USER)
    |=> (t.id_shift[31:7] == bst_pkg::USER_FIXED) && (t.id_shift[6:0] == $past(t.uc_s2)))
    else $error("User signature capture wrong");

  chk_bypass_delay: assert property (@(posedge TCK_IN) disable iff (t.rst_s2)
    (t.state == bst_pkg::ST_SH_DR && dr_sel(t.ir, t.cfg_active) == bst_pkg::SEL_BYP) [*2]
    |-> ##1 (TDO_OUT == $past(TDI_IN, 1)))
    else $error("Bypass path is not one stage long");

  chk_preload_cells: assert property (@(posedge TCK_IN) disable iff (t.rst_s2)
    (t.state == bst_pkg::ST_UPD_DR && dr_sel(t.ir, t.cfg_active) == bst_pkg::SEL_BSR)
    |=> (PIN_TEST_OUT == $past(t.bsr_shift)))
    else $error("Update cells did not take the shifted pattern");

  chk_extest_drive: assert property (@(posedge TCK_IN) disable iff (t.rst_s2)
    PIN_TEST_EN_OUT |-> (t.ir == bst_pkg::OP_EXTEST))
    else $error("Pins driven without external test loaded");

  chk_no_test_cfg: assert property (@(posedge TCK_IN) disable iff (t.rst_s2)
    t.cfg_active |-> !PIN_TEST_EN_OUT ##1 ($stable(t.bsr_shift) && $stable(PIN_TEST_OUT)))
    else $error("Scan test active during configuration");

  chk_unknown_bypass: assert property (@(posedge TCK_IN) disable iff (t.rst_s2)
    (t.ir == bst_pkg::OP_BYPASS || t.ir > bst_pkg::OP_USERCODE) |-> dr_sel(t.ir, t.cfg_active) == bst_pkg::SEL_BYP)
    else $error("Unassigned opcode not treated as bypass");

  chk_cfg_handoff: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
    (CFG_VALID_OUT && !CFG_READY_IN) |=> CFG_VALID_OUT && $stable(CFG_DATA_OUT))
    else $error("Configuration word dropped under back-pressure");

  cov_id_read: cover property (@(posedge TCK_IN) disable iff (t.rst_s2)
    (t.state == bst_pkg::ST_SH_DR && dr_sel(t.ir, t.cfg_active) == bst_pkg::SEL_ID) [*8]);
  cov_extest: cover property (@(posedge TCK_IN) disable iff (t.rst_s2) PIN_TEST_EN_OUT);
  cov_cfg_word: cover property (@(posedge CORE_CLK_IN) disable iff (SRST_IN) CFG_VALID_OUT && CFG_READY_IN);
  cov_fifo_full: cover property (@(posedge CORE_CLK_IN) disable iff (SRST_IN) !fifo_in_ready);

endmodule : bst_test_port

`default_nettype wire

// ### verif/bst_ctrl_model.sv
// Test controller model: makes TCK only during scans and drives TMS and TDI.
// Assumes the port samples on rising TCK and moves TDO on falling TCK.
`default_nettype none
module bst_ctrl_model (
  // Test access lines
  output logic      tck_out,
  output logic      tms_out,
  output logic      tdi_out,
  input  wire logic tdo_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b0;
  end
  // One 125 ns period; TDO is read just before the edge that shifts it
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    tms_out = tms;
    tdi_out = tdi;
    #62 tdo = tdo_in;
    tck_out = 1'b1;
    #63 tck_out = 1'b0;
  endtask : step
  // Idle, scan, back to idle; LSB first, TMS high on the last bit
  task automatic scan(input logic ir, input int n, input logic [437:0] din, output logic [437:0] dout);
    logic d;
    dout = '0;
    step(1'b1, ~tdi_out, d);
    if (ir) step(1'b1, ~tdi_out, d);
    repeat (2) step(1'b0, ~tdi_out, d);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], d);
      dout[i] = d;
    end
    step(1'b1, ~tdi_out, d);
    step(1'b0, ~tdi_out, d);
  endtask : scan
endmodule : bst_ctrl_model
`default_nettype wire

// ### verif/test_boundary_scan_test_port.sv
// Bench for the test port: controller model on the link, queue model of the configuration stream.
// Assumes the controller model holds TCK still between scans.
`default_nettype none
module test_boundary_scan_test_port;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BL = bst_pkg::BSR_LEN;
  logic          clk = 1'b0, srst = 1'b1, rdy = 1'b0, stall = 1'b1;
  logic          tck, tms, tdi, tdo, oe, en, vld, cfg, d, pad;
  logic [BL-1:0] pins = '0, pt, din, dout;
  logic [6:0]    user = '0;
  logic [7:0]    cd, exp_q[$];
  int            err_count = 0, checks_done = 0;
  always #25 clk = ~clk;
  // Weak pull-up: a released data-out line reads high at the controller
  assign pad = oe ? tdo : 1'b1;
  bst_ctrl_model ctrl_u (.tck_out(tck), .tms_out(tms), .tdi_out(tdi), .tdo_in(pad));
  bst_test_port dut_u (.CORE_CLK_IN(clk), .SRST_IN(srst), .TCK_IN(tck), .TMS_IN(tms), .TDI_IN(tdi),
    .TDO_OUT(tdo), .TDO_OE_OUT(oe), .PIN_LEVEL_IN(pins), .PIN_TEST_OUT(pt), .PIN_TEST_EN_OUT(en),
    .USER_CODE_IN(user), .CFG_DATA_OUT(cd), .CFG_VALID_OUT(vld), .CFG_READY_IN(rdy), .CONFIGURING_OUT(cfg));
  task automatic chk(input logic [BL-1:0] got, input logic [BL-1:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  task automatic sc(input logic ir, input int n, input logic [BL-1:0] v);
    ctrl_u.scan(ir, n, v, dout);
    chk(BL'(oe), '0);
  endtask : sc
  task automatic op(input logic [9:0] c);
    sc(1'b1, 10, BL'(c));
    chk(dout, BL'(bst_pkg::IR_CAPTURE));
  endtask : op
  task automatic till_cfg(input logic lvl);
    for (int k = 0; k < 300 && cfg !== lvl; k++) @(posedge clk);
    chk(BL'(cfg), BL'(lvl));
    if (cfg !== lvl) summarize();
  endtask : till_cfg
  // Core side stalls, then accepts at random
  always @(negedge clk) rdy <= stall ? 1'b0 : 1'($urandom_range(0, 1));
  always @(posedge clk) if (vld === 1'b1 && rdy === 1'b1) chk(BL'(cd), BL'(exp_q.pop_front()));
  initial begin
    void'($urandom(18));
    // Reset is stretched so TCK sees enough edges inside it
    repeat (4) ctrl_u.step(1'b1, 1'b0, d);
    @(negedge clk) srst = 1'b0;
    repeat (4) ctrl_u.step(1'b1, 1'b0, d);
    ctrl_u.step(1'b0, 1'b0, d);
    sc(1'b0, 32, '0);
    chk(dout, BL'({bst_pkg::ID_VERSION, bst_pkg::ID_PART, bst_pkg::ID_MAKER, 1'b1}));
    @(negedge clk) user = 7'($urandom);
    op(bst_pkg::OP_USERCODE);
    sc(1'b0, 32, '0);
    chk(dout, BL'({bst_pkg::USER_FIXED, user}));
    for (int i = 0; i < 2; i++) begin
      din = BL'($urandom);
      op(i ? 10'h155 : bst_pkg::OP_BYPASS);
      sc(1'b0, 9, din);
      chk(dout, BL'({din[7:0], 1'b0}));
    end
    @(negedge clk) pins = BL'({14{$urandom}});
    op(bst_pkg::OP_SAMPLE);
    sc(1'b0, BL, ~pins);
    chk(dout, pins);
    chk(pt, ~pins);
    chk(BL'(en), '0);
    op(bst_pkg::OP_EXTEST);
    sc(1'b0, BL, pins);
    chk(dout, pins);
    chk(pt, pins);
    chk(BL'(en), BL'(1));
    op(bst_pkg::OP_CFG_START);
    till_cfg(1'b1);
    op(bst_pkg::OP_SAMPLE);
    sc(1'b0, 2, BL'(3));
    chk(dout, BL'(2));
    op(bst_pkg::OP_CFG_DATA);
    repeat (4) begin
      din = BL'($urandom_range(0, 255));
      exp_q.push_back(din[7:0]);
      sc(1'b0, 8, din);
      chk(BL'(dout[1]), '0);
    end
    stall = 1'b0;
    for (int k = 0; k < 300 && exp_q.size() > 0; k++) @(posedge clk);
    chk(BL'(exp_q.size()), '0);
    op(bst_pkg::OP_CFG_DONE);
    till_cfg(1'b0);
    summarize();
  end
endmodule : test_boundary_scan_test_port
`default_nettype wire
